/* pgsel_top.sv */
// parameter group priority selector with apb registers and event output
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "pgsel_regs.svh"
// Notes on behaviour
// - fixed priority, group 1 highest, group 8 lowest.
// - each request may be a short pulse or a held level.
// - group 1 held ignores all other requests.
// - group 2 held ignores all but group 1.
// - held group 3 to 7 blocks every lower group.
// - held group 8 never blocks anything.
// - no automatic return to group 1; only a group 1 request.
// - every status change raises an event carrying a time stamp.
// - setting picks whether on, off or both events are stored.
// - remote and local change requests raise on and off events.
// - request for an unconfigured group rejected with a failure event pair.
// - request losing to higher priority rejected with a failure event pair.
// - forced request while forcing disabled rejected with a failure pair.
// - remote change request raises on when asserted, off when released.
// - pulse selected group stays active until another request arrives.
// - forcing enabled overrides inputs; forced choice alone decides.
// - remote request cannot win over a higher held group.
// - after reset only group 1 enabled and active; logic idle.
module pgsel_top (
  input  wire logic                      I_CLOCK,
  input  wire logic                      I_RST,
  input  wire logic                      I_PSEL,
  input  wire logic                      I_PENABLE,
  input  wire logic                      I_PWRITE,
  input  wire logic [7:0]                I_PADDR,
  input  wire pgsel_pkg::pgsel_word_type I_PWDATA,
  output pgsel_pkg::pgsel_word_type      O_PRDATA,
  output logic                           O_PREADY,
  output logic                           O_PSLVERR,
  input  wire pgsel_pkg::pgsel_vec_type  I_GROUP_REQ,
  output pgsel_pkg::pgsel_grp_type       O_ACTIVE_GROUP,
  output pgsel_pkg::pgsel_vec_type       O_ACTIVE_ONEHOT,
  output logic                           O_EVT_VALID,
  output pgsel_pkg::pgsel_evt_type       O_EVT_CODE,
  output logic                           O_EVT_ON,
  output pgsel_pkg::pgsel_word_type      O_EVT_STAMP
);
  import pgsel_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pgsel_vec_type  req_s1_reg;
  pgsel_vec_type  req_s2_reg;
  logic [2:0]     used_reg;
  logic           force_en_reg;
  logic [1:0]     store_reg;
  logic [3:0]     force_sel_reg;
  logic [3:0]     remote_sel_reg;
  logic           remote_pulse_reg;
  pgsel_grp_type  active_reg;
  pgsel_grp_type  active_next;
  pgsel_word_type time_reg;
  pgsel_word_type prdata_reg;
  pgsel_word_type rd_mux;
  pgsel_evt_type  last_code_reg;
  logic           last_on_reg;
  logic           last_valid_reg;
  logic           evt_fresh_reg;
  pgsel_word_type last_stamp_reg;
  pgsel_vec_type  cfg_mask;
  pgsel_vec_type  force_oh;
  pgsel_vec_type  remote_oh;
  pgsel_vec_type  active_oh;
  pgsel_vec_type  req_all;
  pgsel_vec_type  req_cfg;
  pgsel_grp_type  win;
  logic           found;
  logic           lose;
  logic           force_ok;
  logic           fail_cfg;
  logic           fail_force;
  logic           fail_prio;
  logic           mapped;
  logic           setup;
  logic           access;
  logic           wr_en;
  logic           rd_event;
  logic [`PGSEL_EVENTS-1:0] ev_level;
  logic           evt_valid;
  pgsel_evt_type  evt_code;
  logic           evt_on;
  pgsel_word_type evt_stamp;

  // ----------------------------------------------------------------
  // request input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      req_s1_reg <= 8'h00;
      req_s2_reg <= 8'h00;
    end else begin
      req_s1_reg <= I_GROUP_REQ;
      req_s2_reg <= req_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // per group masks
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PGSEL_GROUPS; g = g + 1) begin : g_grp
      assign cfg_mask[g]  = (3'(g) <= used_reg);
      assign force_oh[g]  = (force_sel_reg == 4'(g + 1));
      assign remote_oh[g] = (remote_sel_reg == 4'(g + 1));
      assign active_oh[g] = (active_reg == 3'(g));
    end
  endgenerate

  // ----------------------------------------------------------------
  // request resolution
  // ----------------------------------------------------------------
  // pulses and levels share one vector
  assign req_all = req_s2_reg | (remote_oh & {8{remote_pulse_reg}});
  assign req_cfg = req_all & cfg_mask;

  always_comb begin
    found = 1'b0;
    lose  = 1'b0;
    win   = 3'h0;
    for (int i = 0; i < `PGSEL_GROUPS; i++) begin
      if (req_cfg[i]) begin
        if (found) begin
          lose = 1'b1;
        end else begin
          found = 1'b1;
          win   = 3'(i);
        end
      end
    end
  end

  assign force_ok = |(force_oh & cfg_mask);

  always_comb begin
    active_next = active_reg;
    if (force_en_reg) begin
      if (force_ok) begin
        active_next = 3'(force_sel_reg - 4'h1);
      end
    end else if (found) begin
      active_next = win;
    end
  end

  // ----------------------------------------------------------------
  // failure levels
  // ----------------------------------------------------------------
  assign fail_cfg = (|(req_all & ~cfg_mask))
                    || (force_en_reg && (|force_oh) && !force_ok);
  assign fail_force = (|force_oh) && !force_en_reg;
  assign fail_prio  = lose && !force_en_reg;

  // ----------------------------------------------------------------
  // active group register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      active_reg <= `PGSEL_RST_ACTIVE;
    end else begin
      active_reg <= active_next;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_ACTIVE_GROUP  <= `PGSEL_RST_ACTIVE;
      O_ACTIVE_ONEHOT <= 8'h01;
    end else begin
      O_ACTIVE_GROUP  <= active_next;
      O_ACTIVE_ONEHOT <= 8'(8'h01 << active_next);
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup    = I_PSEL && !I_PENABLE;
  assign access   = I_PSEL && I_PENABLE;
  assign wr_en    = access && I_PWRITE && mapped;
  assign rd_event = access && !I_PWRITE && (I_PADDR == `PGSEL_OFF_EVENT);

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    case (I_PADDR)
      `PGSEL_OFF_CTRL: begin
        rd_mux[`PGSEL_CTRL_USED]  = used_reg;
        rd_mux[`PGSEL_CTRL_FORCE] = force_en_reg;
        rd_mux[`PGSEL_CTRL_STORE] = store_reg;
      end
      `PGSEL_OFF_FORCE: begin
        rd_mux[`PGSEL_SEL_FIELD] = force_sel_reg;
      end
      `PGSEL_OFF_REMOTE: begin
        rd_mux[`PGSEL_SEL_FIELD] = remote_sel_reg;
      end
      `PGSEL_OFF_STATUS: begin
        rd_mux[`PGSEL_ST_ACTIVE] = active_reg;
        rd_mux[`PGSEL_ST_REQ]    = req_s2_reg;
        rd_mux[`PGSEL_ST_FAIL]   = {fail_prio, fail_force, fail_cfg};
      end
      `PGSEL_OFF_EVENT: begin
        rd_mux[`PGSEL_EV_CODE]  = last_code_reg;
        rd_mux[`PGSEL_EV_ON]    = last_on_reg;
        rd_mux[`PGSEL_EV_VALID] = last_valid_reg;
      end
      `PGSEL_OFF_STAMP: begin
        rd_mux = last_stamp_reg;
      end
      `PGSEL_OFF_TIME: begin
        rd_mux = time_reg;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  assign O_PREADY  = access;
  assign O_PSLVERR = access && !mapped;
  assign O_PRDATA  = prdata_reg;

  // read data caught in the setup cycle
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      prdata_reg <= 32'h00000000;
    end else if (setup) begin
      prdata_reg <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      used_reg     <= `PGSEL_RST_USED;
      force_en_reg <= `PGSEL_RST_FORCE_EN;
      store_reg    <= `PGSEL_RST_STORE;
    end else if (wr_en && (I_PADDR == `PGSEL_OFF_CTRL)) begin
      used_reg     <= I_PWDATA[`PGSEL_CTRL_USED];
      force_en_reg <= I_PWDATA[`PGSEL_CTRL_FORCE];
      store_reg    <= I_PWDATA[`PGSEL_CTRL_STORE];
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      force_sel_reg <= `PGSEL_RST_SEL;
    end else if (wr_en && (I_PADDR == `PGSEL_OFF_FORCE)) begin
      force_sel_reg <= I_PWDATA[`PGSEL_SEL_FIELD];
    end
  end

  // remote write gives a one cycle request pulse unless forcing is on or the selection written is 0
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      remote_sel_reg   <= `PGSEL_RST_SEL;
      remote_pulse_reg <= 1'b0;
    end else begin
      remote_pulse_reg <= 1'b0;
      if (wr_en && (I_PADDR == `PGSEL_OFF_REMOTE)) begin
        remote_sel_reg   <= I_PWDATA[`PGSEL_SEL_FIELD];
        remote_pulse_reg <= !force_en_reg && (I_PWDATA[`PGSEL_SEL_FIELD] != 4'h0);
      end
    end
  end

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      time_reg <= 32'h00000000;
    end else begin
      time_reg <= time_reg + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // event sources and issuer
  // ----------------------------------------------------------------
  assign ev_level = {active_oh,
                     fail_prio, fail_force, fail_cfg,
                     force_en_reg,
                     |force_oh,
                     |remote_oh,
                     req_s2_reg,
                     cfg_mask[7:1]};

  pgsel_evq u_evq (
    .i_clk       (I_CLOCK),
    .i_rst       (I_RST),
    .i_level     (ev_level),
    .i_store_on  (store_reg[0]),
    .i_store_off (store_reg[1]),
    .i_stamp     (time_reg),
    .o_valid     (evt_valid),
    .o_code      (evt_code),
    .o_on        (evt_on),
    .o_stamp     (evt_stamp)
  );

  assign O_EVT_VALID = evt_valid;
  assign O_EVT_CODE  = evt_code;
  assign O_EVT_ON    = evt_on;
  assign O_EVT_STAMP = evt_stamp;

  // ----------------------------------------------------------------
  // last event holding register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      last_code_reg  <= 5'h00;
      last_on_reg    <= 1'b0;
      last_stamp_reg <= 32'h00000000;
    end else if (evt_valid) begin
      last_code_reg  <= evt_code;
      last_on_reg    <= evt_on;
      last_stamp_reg <= evt_stamp;
    end
  end

  // new event since the read setup keeps valid set
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      evt_fresh_reg <= 1'b0;
    end else if (setup) begin
      evt_fresh_reg <= evt_valid;
    end else begin
      evt_fresh_reg <= evt_fresh_reg || evt_valid;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      last_valid_reg <= 1'b0;
    end else if (evt_valid) begin
      last_valid_reg <= 1'b1;
    end else if (rd_event && !evt_fresh_reg) begin
      last_valid_reg <= 1'b0;
    end
  end
endmodule

/* pgsel_regs.svh */
// register offsets, fields, reset values and event indices
`ifndef PGSEL_REGS_SVH
`define PGSEL_REGS_SVH
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PGSEL_GROUPS        8
`define PGSEL_EVENTS        29
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PGSEL_OFF_CTRL      8'h00
`define PGSEL_OFF_FORCE     8'h04
`define PGSEL_OFF_REMOTE    8'h08
`define PGSEL_OFF_STATUS    8'h0C
`define PGSEL_OFF_EVENT     8'h10
`define PGSEL_OFF_STAMP     8'h14
`define PGSEL_OFF_TIME      8'h18
// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define PGSEL_CTRL_USED     2:0
`define PGSEL_CTRL_FORCE    3
`define PGSEL_CTRL_STORE    5:4
`define PGSEL_SEL_FIELD     3:0
`define PGSEL_ST_ACTIVE     2:0
`define PGSEL_ST_REQ        15:8
`define PGSEL_ST_FAIL       18:16
`define PGSEL_EV_CODE       4:0
`define PGSEL_EV_ON         5
`define PGSEL_EV_VALID      6
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PGSEL_RST_USED      3'h0
`define PGSEL_RST_FORCE_EN  1'h0
`define PGSEL_RST_STORE     2'h3
`define PGSEL_RST_SEL       4'h0
`define PGSEL_RST_ACTIVE    3'h0
// ----------------------------------------------------------------
// event indices (code reported on the event port)
// ----------------------------------------------------------------
`define PGSEL_EV_ENABLED    0
`define PGSEL_EV_REQ        7
`define PGSEL_EV_REMOTE     15
`define PGSEL_EV_LOCAL      16
`define PGSEL_EV_FORCE      17
`define PGSEL_EV_FAIL_CFG   18
`define PGSEL_EV_FAIL_FORCE 19
`define PGSEL_EV_FAIL_PRIO  20
`define PGSEL_EV_ACTIVE     21
`endif

/* pgsel_pkg.sv */
// types shared by the group selector files
package pgsel_pkg;
  typedef logic [2:0]  pgsel_grp_type;
  typedef logic [4:0]  pgsel_evt_type;
  typedef logic [7:0]  pgsel_vec_type;
  typedef logic [31:0] pgsel_word_type;
endpackage

/* pgsel_evq.sv */
// event edge detector and one-per-cycle event issuer
`timescale 1ns/1ps
`include "pgsel_regs.svh"
module pgsel_evq (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic [`PGSEL_EVENTS-1:0] i_level,
  input  wire logic                     i_store_on,
  input  wire logic                     i_store_off,
  input  wire pgsel_pkg::pgsel_word_type i_stamp,
  output logic                          o_valid,
  output pgsel_pkg::pgsel_evt_type      o_code,
  output logic                          o_on,
  output pgsel_pkg::pgsel_word_type     o_stamp
);
  import pgsel_pkg::*;

  logic [`PGSEL_EVENTS-1:0] prev_reg;
  logic [`PGSEL_EVENTS-1:0] pend_on_reg;
  logic [`PGSEL_EVENTS-1:0] pend_off_reg;
  logic [`PGSEL_EVENTS-1:0] grant_on;
  logic [`PGSEL_EVENTS-1:0] grant_off;
  pgsel_evt_type            sel;
  logic                     sel_on;
  logic                     hit;

  // ----------------------------------------------------------------
  // per event edge capture
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PGSEL_EVENTS; g = g + 1) begin : g_ev
      assign grant_on[g]  = hit && sel_on && (sel == 5'(g));
      assign grant_off[g] = hit && !sel_on && (sel == 5'(g));
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          prev_reg[g]     <= 1'b0;
          pend_on_reg[g]  <= 1'b0;
          pend_off_reg[g] <= 1'b0;
        end else begin
          prev_reg[g] <= i_level[g];
          // new edge wins over the grant clear
          pend_on_reg[g] <= (i_level[g] && !prev_reg[g] && i_store_on)
                            || (pend_on_reg[g] && !grant_on[g]);
          pend_off_reg[g] <= (!i_level[g] && prev_reg[g] && i_store_off)
                             || (pend_off_reg[g] && !grant_off[g]);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // pick lowest pending, on before off
  // ----------------------------------------------------------------
  always_comb begin
    hit    = 1'b0;
    sel    = 5'h00;
    sel_on = 1'b0;
    for (int i = 0; i < `PGSEL_EVENTS; i++) begin
      if (!hit && pend_on_reg[i]) begin
        hit    = 1'b1;
        sel    = 5'(i);
        sel_on = 1'b1;
      end
    end
    for (int i = 0; i < `PGSEL_EVENTS; i++) begin
      if (!hit && pend_off_reg[i]) begin
        hit = 1'b1;
        sel = 5'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // issue with time stamp
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_code  <= 5'h00;
      o_on    <= 1'b0;
      o_stamp <= 32'h00000000;
    end else begin
      o_valid <= hit;
      if (hit) begin
        o_code  <= sel;
        o_on    <= sel_on;
        o_stamp <= i_stamp;
      end
    end
  end
endmodule

/* pgsel_chk.sv */
// port level assertions for the parameter group selector
`timescale 1ns/1ps
module pgsel_chk (
  input wire logic        I_CLOCK,
  input wire logic        I_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic        O_PSLVERR,
  input wire logic [7:0]  I_GROUP_REQ,
  input wire logic [2:0]  O_ACTIVE_GROUP,
  input wire logic [7:0]  O_ACTIVE_ONEHOT,
  input wire logic        O_EVT_VALID,
  input wire logic        O_EVT_ON,
  input wire logic [31:0] O_EVT_STAMP
);
  // ----------------------------------------------------------------
  // shadow of the written settings
  // ----------------------------------------------------------------
  logic       wr;
  logic [2:0] used_reg;
  logic       frc_reg;
  logic [1:0] store_reg;
  logic [5:0] age_reg;
  logic [3:0] fsel_reg;
  assign wr = I_PSEL && I_PENABLE && I_PWRITE;
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      used_reg  <= 3'h0;
      frc_reg   <= 1'h0;
      store_reg <= 2'h3;
      age_reg   <= 6'h0;
    end else if (wr && I_PADDR == 8'h00) begin
      used_reg  <= I_PWDATA[2:0];
      frc_reg   <= I_PWDATA[3];
      store_reg <= I_PWDATA[5:4];
      age_reg   <= 6'h0;
    end else if (age_reg != 6'h3F) begin
      age_reg <= age_reg + 6'h1;
    end
  end
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      fsel_reg <= 4'h0;
    end else if (wr && I_PADDR == 8'h04) begin
      fsel_reg <= I_PWDATA[3:0];
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  onehot_map_a: assert property (
    O_ACTIVE_ONEHOT == (8'h01 << O_ACTIVE_GROUP)) else $error("onehot differs from index");
  for (genvar k = 0; k < 7; k++) begin : g_hold
    hold_block_a: assert property (
      (I_GROUP_REQ[k] && !frc_reg && used_reg >= k)[*5] |-> O_ACTIVE_GROUP <= k)
      else $error("lower group beat a held request");
  end
  idle_stable_a: assert property (
    (I_GROUP_REQ == 8'h00 && !wr)[*5] |-> $stable(O_ACTIVE_GROUP))
    else $error("active group moved with no request");
  force_sel_a: assert property (
    (frc_reg && fsel_reg != 4'h0 && fsel_reg <= {1'b0, used_reg} + 4'h1)[*3]
    |-> O_ACTIVE_GROUP == 3'(fsel_reg - 4'h1)) else $error("forced group not active");
  force_hold_a: assert property (
    (frc_reg && $stable(fsel_reg) && $stable(used_reg))[*4] |-> $stable(O_ACTIVE_GROUP))
    else $error("inputs moved group while forced");
  stamp_step_a: assert property (
    O_EVT_VALID && $past(O_EVT_VALID) |-> O_EVT_STAMP == $past(O_EVT_STAMP) + 32'h1)
    else $error("stamp step wrong");
  store_mode_a: assert property (
    O_EVT_VALID && age_reg == 6'h3F |-> (O_EVT_ON ? store_reg[0] : store_reg[1]))
    else $error("event kind not enabled");
  slverr_map_a: assert property (
    I_PSEL && I_PENABLE |-> O_PSLVERR == (I_PADDR > 8'h18 || I_PADDR[1:0] != 2'h0))
    else $error("slave error mismatch");
  cover property (frc_reg && O_ACTIVE_GROUP == 3'h4);
  cover property (O_EVT_VALID && O_EVT_ON);
  cover property (I_PSEL && I_PENABLE && O_PSLVERR);
endmodule
bind pgsel_top pgsel_chk u_pgsel_chk (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .O_PSLVERR(O_PSLVERR), .I_GROUP_REQ(I_GROUP_REQ), .O_ACTIVE_GROUP(O_ACTIVE_GROUP),
  .O_ACTIVE_ONEHOT(O_ACTIVE_ONEHOT), .O_EVT_VALID(O_EVT_VALID), .O_EVT_ON(O_EVT_ON),
  .O_EVT_STAMP(O_EVT_STAMP));

/* pgsel_req_src.sv */
// request source standing in for inputs and application logic
`timescale 1ns/1ps
module pgsel_req_src (
  input  wire logic                     i_clk,
  input  wire pgsel_pkg::pgsel_vec_type i_level,
  input  wire pgsel_pkg::pgsel_vec_type i_pulse,
  output pgsel_pkg::pgsel_vec_type      o_req
);
  import pgsel_pkg::*;
  pgsel_vec_type pulse_reg = 8'h00;
  logic [1:0]    cnt_reg   = 2'h0;
  // pulse held four cycles to clear the synchroniser
  always_ff @(posedge i_clk) begin
    if (i_pulse != 8'h00) begin
      pulse_reg <= i_pulse;
      cnt_reg   <= 2'h3;
    end else if (cnt_reg != 2'h0) begin
      cnt_reg <= cnt_reg - 2'h1;
    end else begin
      pulse_reg <= 8'h00;
    end
  end
  assign o_req = i_level | pulse_reg;
endmodule

/* pgsel_top_tb.sv */
// self-checking bench for the parameter group selector
`timescale 1ns/1ps
module pgsel_top_tb;
  import pgsel_pkg::*;
  logic           clk;
  logic           rst;
  logic           psel;
  logic           pen;
  logic           pwr;
  logic [7:0]     paddr;
  pgsel_word_type pwdata;
  pgsel_word_type prdata;
  logic           pready;
  logic           pslverr;
  pgsel_vec_type  lvl;
  pgsel_vec_type  pls;
  pgsel_vec_type  req;
  pgsel_grp_type  act;
  pgsel_vec_type  onehot;
  logic           ev_v;
  pgsel_evt_type  ev_c;
  logic           ev_o;
  pgsel_word_type ev_s;
  logic [28:0]    seen_on;
  logic [28:0]    seen_off;
  pgsel_word_type rd;
  logic           err;
  int             bad_count;
  int             check_count;
  pgsel_top u_pgsel_top (.I_CLOCK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_GROUP_REQ(req), .O_ACTIVE_GROUP(act),
    .O_ACTIVE_ONEHOT(onehot), .O_EVT_VALID(ev_v), .O_EVT_CODE(ev_c), .O_EVT_ON(ev_o),
    .O_EVT_STAMP(ev_s));
  pgsel_req_src u_pgsel_req_src (.i_clk(clk), .i_level(lvl), .i_pulse(pls), .o_req(req));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ev_v === 1'b1 && ev_o === 1'b1) seen_on[ev_c] <= 1'b1;
    if (ev_v === 1'b1 && ev_o === 1'b0) seen_off[ev_c] <= 1'b1;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_w(input string nm, input pgsel_word_type e, input pgsel_word_type g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_g(input string nm, input pgsel_grp_type e);
    check_count++;
    if (act !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, act);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input pgsel_word_type d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) begin
      $display("[FAIL] pready expected 1 seen %b", pready);
      bad_count++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic pulse(input pgsel_vec_type m);
    @(posedge clk);
    pls <= m;
    @(posedge clk);
    pls <= 8'h00;
    cyc(20);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk_g("active", 3'h0);
    chk_w("onehot", 32'h1, {24'h0, onehot});
    apb(1'b0, 8'h00, 32'h0);
    chk_w("ctrl", 32'h30, rd);
    apb(1'b0, 8'h1C, 32'h0);
    chk_w("slverr", 32'h1, {31'h0, err});
    chk_w("act1 on", 32'h1, {31'h0, seen_on[21]});
    $display("t_reset done");
  endtask
  task automatic t_cfg();
    lvl <= 8'h04;
    cyc(40);
    chk_g("unconfigured", 3'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk_w("status", 32'h00010400, rd & 32'h0003FFFF);
    lvl <= 8'h00;
    cyc(40);
    chk_w("cfg fail", 32'h3, {30'h0, seen_on[18], seen_off[18]});
    chk_w("req3", 32'h3, {30'h0, seen_on[9], seen_off[9]});
    $display("t_cfg done");
  endtask
  task automatic t_prio();
    apb(1'b1, 8'h00, 32'h37);
    for (int k = 7; k >= 0; k--) begin
      lvl <= lvl | (8'h01 << k);
      cyc(8);
      chk_g("held winner", 3'(k));
    end
    apb(1'b0, 8'h0C, 32'h0);
    chk_w("prio fail", 32'h00040000, rd & 32'h00040000);
    lvl <= 8'hFE;
    cyc(8);
    chk_g("group2 held", 3'h1);
    lvl <= 8'h00;
    cyc(40);
    chk_g("no return", 3'h1);
    chk_w("prio ev", 32'h1, {31'h0, seen_on[20]});
    $display("t_prio done");
  endtask
  task automatic t_pulse();
    seen_on = '0;
    seen_off = '0;
    pulse(8'h10);
    chk_g("pulse5", 3'h4);
    cyc(20);
    chk_w("req5", 32'h3, {30'h0, seen_on[11], seen_off[11]});
    chk_w("act", 32'h3, {30'h0, seen_on[25], seen_off[22]});
    pulse(8'h80);
    chk_g("pulse8", 3'h7);
    pulse(8'h01);
    chk_g("pulse1", 3'h0);
    $display("t_pulse done");
  endtask
  task automatic t_remote();
    seen_on = '0;
    seen_off = '0;
    apb(1'b1, 8'h08, 32'h3);
    cyc(30);
    chk_g("remote3", 3'h2);
    apb(1'b1, 8'h08, 32'h0);
    cyc(10);
    chk_w("remote ev", 32'h3, {30'h0, seen_on[15], seen_off[15]});
    lvl <= 8'h02;
    cyc(8);
    apb(1'b1, 8'h08, 32'h6);
    cyc(8);
    chk_g("remote blocked", 3'h1);
    $display("t_remote done");
  endtask
  task automatic t_force();
    seen_on = '0;
    seen_off = '0;
    apb(1'b1, 8'h04, 32'h5);
    apb(1'b0, 8'h0C, 32'h0);
    chk_w("force fail", 32'h00020000, rd & 32'h00020000);
    apb(1'b1, 8'h00, 32'h3F);
    cyc(8);
    chk_g("forced", 3'h4);
    lvl <= 8'h01;
    cyc(40);
    chk_g("inputs ignored", 3'h4);
    chk_w("force evs", 32'h7, {29'h0, seen_on[19], seen_off[19], seen_on[17]});
    chk_w("local ev", 32'h1, {31'h0, seen_on[16]});
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h37);
    cyc(8);
    chk_g("released", 3'h0);
    lvl <= 8'h00;
    $display("t_force done");
  endtask
  task automatic t_store(input pgsel_word_type c, input pgsel_vec_type m,
                         input pgsel_word_type ev);
    apb(1'b1, 8'h00, c);
    cyc(70);
    seen_on = '0;
    seen_off = '0;
    pulse(m);
    cyc(40);
    chk_w("on kept", {31'h0, c[4]}, {31'h0, |seen_on});
    chk_w("off kept", {31'h0, c[5]}, {31'h0, |seen_off});
    apb(1'b0, 8'h10, 32'h0);
    chk_w("last event", ev, rd & 32'h7F);
    apb(1'b0, 8'h10, 32'h0);
    chk_w("event cleared", 32'h0, rd & 32'h40);
    $display("t_store done");
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lvl = 8'h00;
    pls = 8'h00;
    seen_on = '0;
    seen_off = '0;
    bad_count = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cyc(40);
    t_reset();
    t_cfg();
    t_prio();
    t_pulse();
    t_remote();
    t_force();
    t_store(32'h17, 8'h04, 32'h77);
    t_store(32'h27, 8'h08, 32'h4A);
    final_report();
  end
endmodule
